// ### design/lfs_defs.vh
// constants for the led fault status bank
// How it works
// - writing one to summary flag and clear bit together clears all fault flags and irq status bit 0
// - bit 10 reads one while any open, short or ground fault is latched
// - bit 8 reads one when a string is shorted to ground
// - bit 7 reads one when an internal string short was detected
// - bit 6 reads one when an open string was detected
// - short and open flags clear only with the paired summary clear
// - bits 3 to 0 are per-string fault flags, strings four to one
// - read-only state machine diagnostic register at 14h, not reset, follows live_state_code
// - low five bits report the live state code
`ifndef LFS_DEFS_VH
`define LFS_DEFS_VH
`define LFS_ADDR_STATUS   8'h10
`define LFS_ADDR_DIAG     8'h14
`define LFS_ADDR_IRQ_STAT 8'h20
`define LFS_ADDR_IRQ_MASK 8'h24
`define LFS_BIT_SUMMARY   10
`define LFS_BIT_CLEAR     9
`define LFS_BIT_GND       8
`define LFS_BIT_SHORT     7
`define LFS_BIT_OPEN      6
`define LFS_STATE_W       5
`define LFS_RESET_VAL     32'h0000_0000
`define LFS_MASK_RESET    2'h0
`endif

// ### design/lfs_latch.v
// one sticky fault flag, set wins over clear
`timescale 1ns/1ps
module lfs_latch (
	clk,
	srst,
	set,
	clr,
	flag_q
);
	input  wire clk;
	input  wire srst;
	input  wire set;
	input  wire clr;
	output reg  flag_q;

	always @(posedge clk)
	begin
		if (srst)
			flag_q <= 1'b0;
		else if (set)
			flag_q <= 1'b1;
		else if (clr)
			flag_q <= 1'b0;
	end
endmodule // lfs_latch

// ### design/lfs_bank.v
// led fault status bank with apb slave and interrupt
`timescale 1ns/1ps
`include "lfs_defs.vh"
module lfs_bank (
	clk,
	srst,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	det_ground_short,
	det_internal_short,
	det_open_string,
	det_string_fault,
	live_state_code,
	irq
);
	input  wire        clk;
	input  wire        srst;
	input  wire        psel;
	input  wire        penable;
	input  wire        pwrite;
	input  wire [7:0]  paddr;
	input  wire [31:0] pwdata;
	output reg  [31:0] prdata;
	output reg         pready;
	output reg         pslverr;
	input  wire        det_ground_short;
	input  wire        det_internal_short;
	input  wire        det_open_string;
	input  wire [3:0]  det_string_fault;
	input  wire [4:0]  live_state_code;
	output reg         irq;

	////////////////////////////////////////////////////////////////
	// bus decode
	wire        setup_w;
	wire        hit_status;
	wire        hit_diag;
	wire        hit_istat;
	wire        hit_imask;
	wire        mapped;
	wire        wr;
	wire        string_fault_clear_bit;
	assign setup_w    = psel & ~penable;
	assign hit_status = paddr == `LFS_ADDR_STATUS;
	assign hit_diag   = paddr == `LFS_ADDR_DIAG;
	assign hit_istat  = paddr == `LFS_ADDR_IRQ_STAT;
	assign hit_imask  = paddr == `LFS_ADDR_IRQ_MASK;
	assign mapped     = hit_status | hit_diag | hit_istat | hit_imask;
	// write takes effect at the single access edge where pready is high
	assign wr = psel & penable & pready & pwrite & mapped;
	// paired write only; either bit alone does nothing
	assign string_fault_clear_bit = wr & hit_status & pwdata[`LFS_BIT_SUMMARY]
		& pwdata[`LFS_BIT_CLEAR];

	////////////////////////////////////////////////////////////////
	// fault flags
	wire [6:0] set_v;
	wire [6:0] clr_v;
	wire [6:0] flag_v;
	assign set_v = {det_ground_short, det_internal_short, det_open_string,
		det_string_fault};
	// every detail flag drops only with the paired clear
	assign clr_v = {7{string_fault_clear_bit}};

	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1)
		begin : g_flag
			lfs_latch u_latch (
				.clk    (clk),
				.srst   (srst),
				.set    (set_v[g]),
				.clr    (clr_v[g]),
				.flag_q (flag_v[g])
			);
		end
	endgenerate

	wire summary;
	assign summary = flag_v[6] | flag_v[5] | flag_v[4];

	////////////////////////////////////////////////////////////////
	// interrupt status: bit0 led fault, bit1 string fault
	reg  [1:0] istat_q;
	reg  [1:0] imask_q;
	wire [1:0] ev;
	wire [1:0] w1c;
	assign ev  = {|det_string_fault,
		det_ground_short | det_internal_short | det_open_string};
	assign w1c = (wr & hit_istat) ? pwdata[1:0] : 2'h0;

	always @(posedge clk)
	begin
		if (srst)
		begin
			istat_q <= 2'h0;
			imask_q <= `LFS_MASK_RESET;
			irq     <= 1'b0;
		end
		else
		begin
			// set wins over a same-cycle clear
			istat_q[0] <= ev[0] | (istat_q[0] & ~w1c[0] & ~string_fault_clear_bit);
			istat_q[1] <= ev[1] | (istat_q[1] & ~w1c[1]);
			if (wr & hit_imask)
				imask_q <= pwdata[1:0];
			irq <= |(istat_q & imask_q);
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux and handshake; answer one cycle after setup
	reg [31:0] rd_d;
	always @*
	begin
		rd_d = `LFS_RESET_VAL;
		if (hit_status)
		begin
			rd_d[`LFS_BIT_SUMMARY] = summary;
			rd_d[`LFS_BIT_GND]     = flag_v[6];
			rd_d[`LFS_BIT_SHORT]   = flag_v[5];
			rd_d[`LFS_BIT_OPEN]    = flag_v[4];
			// bits 9, 5, 4 read zero; reserved writes ignored
			rd_d[3:0] = flag_v[3:0];
		end
		else if (hit_diag)
			rd_d[`LFS_STATE_W-1:0] = live_state_code;
		else if (hit_istat)
			rd_d[1:0] = istat_q;
		else if (hit_imask)
			rd_d[1:0] = imask_q;
	end

	always @(posedge clk)
	begin
		if (srst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `LFS_RESET_VAL;
		end
		else
		begin
			pready  <= setup_w;
			pslverr <= setup_w & ~mapped;
			if (setup_w & ~pwrite & mapped)
				prdata <= rd_d;
			else if (setup_w)
				prdata <= `LFS_RESET_VAL;
		end
	end
endmodule // lfs_bank

// ### verif/lfs_bank_monitor.sv
// port checker for the led fault status bank
`timescale 1ns/1ps
module lfs_bank_monitor (
	input wire clk, srst, psel, penable, pwrite, pready, pslverr, irq,
	input wire det_ground_short, det_internal_short, det_open_string,
	input wire [3:0] det_string_fault, input wire [4:0] live_state_code,
	input wire [7:0] paddr, input wire [31:0] prdata);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire r = pready && !pwrite && paddr == 8'h10;
	wire [2:0] k = {det_ground_short, det_internal_short, det_open_string};
	rdy_due_a: assert property (psel && !penable |=> pready) else $error("late");
	err_rdy_a: assert property (pslverr |-> pready) else $error("stray");
	diag_live_a:
		assert property (psel && !penable && !pwrite && paddr == 8'h14
		|=> prdata == $past(live_state_code)) else $error("code");
	sum_or_a: assert property (r |-> prdata[10] == |prdata[8:6])
		else $error("sum");
	resv_zero_a: assert property (r |-> !prdata[9] && !prdata[5:4])
		else $error("resv");
	rst_irq_a: assert property (disable iff (1'b0) srst |=> !irq)
		else $error("irq");
	flt_hold_a:
		assert property (r |-> &(prdata[8:6] | ~$past(k, 2))) else $error("lost");
	str_hold_a:
		assert property (r |-> &(prdata[3:0] | ~$past(det_string_fault, 2)))
		else $error("str");
	cover property (irq);
	cover property (pslverr);
	cover property (r && prdata[10]);
endmodule // lfs_bank_monitor

// ### verif/tb_lfs_bank.sv
// bench for the led fault status bank
`timescale 1ns/1ps
module tb_lfs_bank;
	reg clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	reg [6:0] det = 0;
	reg [4:0] live_state_code = 0;
	reg [7:0] paddr = 0;
	reg [31:0] pwdata = 0;
	wire det_ground_short = det[6], det_internal_short = det[5];
	wire det_open_string = det[4];
	wire [3:0] det_string_fault = det[3:0];
	wire [31:0] prdata;
	wire pready, pslverr, irq;
	integer mismatches = 0, checks = 0, i, n;
	lfs_bank u_lfs_bank (.*);
	task finish_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input [33:0] g, e);
		checks = checks + 1;
		if (g !== e)
			mismatches = mismatches + 1;
		if (g !== e)
			$display("MISMATCH %0t got %h", $time, g);
	endtask
	// bounded wait; a missing pready fails the run
	task bus(input [7:0] a, input w, input [31:0] d, e);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk) penable <= 1;
		for (n = 0; n < 9 && pready !== 1; n = n + 1)
			@(posedge clk);
		chk({n < 9, pslverr, w ? e : prdata}, {1'b1, a != 8'h10 &&
			a != 8'h14 && a != 8'h20 && a != 8'h24, e});
		if (n == 9)
			finish_test;
		{psel, penable} <= 0;
		@(posedge clk);
	endtask
	initial forever #5 clk = ~clk;
	initial
	begin
		repeat (16) @(posedge clk);
		srst <= 0;
		bus(8'h10, 0, 0, 0);
		for (i = 0; i < 20; i = i + 1)
		begin
			live_state_code <= i[4:0];
			bus(8'h14, 0, 0, i);
		end
		det <= 7'h40;
		bus(8'h30, 0, 0, 0);
		bus(8'h20, 0, 0, 1);
		chk(irq, 0);
		bus(8'h24, 1, 1, 0);
		det <= 7'h39;
		@(posedge clk);
		chk(irq, 1);
		bus(8'h10, 0, 0, 'h5c9);
		det <= 0;
		bus(8'h10, 1, 'h400, 0);
		bus(8'h10, 1, 'h200, 0);
		bus(8'h10, 0, 0, 'h5c9);
		bus(8'h10, 1, 'h600, 0);
		bus(8'h10, 0, 0, 0);
		chk(irq, 0);
		bus(8'h20, 1, 2, 0);
		bus(8'h20, 0, 0, 0);
		finish_test;
	end
endmodule // tb_lfs_bank
bind lfs_bank lfs_bank_monitor u_lfs_bank_monitor (.*);
